// ### core/ehc_regs.svh
// Register offsets, field positions, reset values and protocol constants
// of the Ethernet header comparator stage.
// Assumes a plain register port with byte addresses and 32-bit data.
`ifndef EHC_REGS_SVH
`define EHC_REGS_SVH

// ----------------------------------------------------------------------
// Comparator identity codes
// ----------------------------------------------------------------------
`define EHC_ID_ETH1 3'h0
`define EHC_ID_ETH2 3'h1
`define EHC_ID_IPA 3'h2
`define EHC_ID_IPB 3'h3
`define EHC_ID_MPLS 3'h4
`define EHC_ID_LAST 3'h5

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define EHC_OFS_NEXT 6'h00
`define EHC_OFS_SIG 6'h04
`define EHC_OFS_HDR 6'h08
`define EHC_OFS_TPV 6'h0c
`define EHC_OFS_CTRL 6'h10
`define EHC_OFS_TYPE 6'h14
`define EHC_OFS_LEN 6'h18
`define EHC_OFS_FACT 6'h1c
`define EHC_OFS_FCH 6'h20
`define EHC_OFS_FTAG 6'h24
`define EHC_OFS_STAT 6'h28

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define EHC_CTRL_BB 0
`define EHC_CTRL_TEN 1
`define EHC_CTRL_MIX 2
`define EHC_STAT_TAGS_LSB 1
`define EHC_STAT_HITS_LSB 8

// ----------------------------------------------------------------------
// Reset values and protocol constants
// ----------------------------------------------------------------------
`define EHC_RST_TPV 16'h8a88
`define EHC_RST_LEN_HI 16'h05ff
`define EHC_CTAG 16'h8100
`define EHC_ITAG 16'h88e7
`define EHC_LEN_LIMIT 16'h0600
`define EHC_SAP_A 8'haa
`define EHC_SAP_B 8'hab
`define EHC_LLC_CTL 8'h03
`define EHC_OUI_ALT 24'h0000f8
`define EHC_ADDR_BYTES 4'hc
`define EHC_LLC_BYTES 4'h3
`define EHC_OUI_BYTES 4'h3
`define EHC_ITAG_BYTES 4'h4

`endif

// ### core/ehc_pkg.sv
// Types shared by the Ethernet header comparator files.
// Assumes ehc_regs.svh supplies the numeric constants.
package ehc_pkg;

   // Parser states: idle, done and one per header field kind.
   typedef enum logic [2:0] {
      EHC_IDLE, EHC_ADDR, EHC_TYPE, EHC_TCI, EHC_ITAG, EHC_LLC, EHC_SNAP, EHC_DONE
   } ehc_state_t;

   // One byte of the aligned frame data path.
   typedef struct packed {
      logic valid;
      logic sof;
      logic eof;
      logic [1:0] chan;
      logic [7:0] data;
   } ehc_byte_t;

   // Hand-over to the encapsulation engine controller.
   typedef struct packed {
      logic valid;
      logic match;
      logic no_modify_signal;
      logic [2:0] next_id;
      logic [7:0] next_pos;
      logic [7:0] sig_pos;
   } ehc_result_t;

endpackage : ehc_pkg

// ### core/ehc_flow_match.sv
// Per-flow gating of the Ethernet comparator.
// Assumes configuration is stable while a header is being parsed.
module ehc_flow_match import ehc_pkg::*; #(
   parameter int FLOWS = 8,
   parameter int CH_W = 2
) (
   // Flow configuration
   input wire logic [FLOWS-1:0] active,
   input wire logic [FLOWS*(1<<CH_W)-1:0] chan_sel,
   input wire logic [2*FLOWS-1:0] tag_cnt,
   // Frame properties
   input wire logic [CH_W-1:0] chan,
   input wire logic [1:0] tags,
   // Per-flow hit
   output logic [FLOWS-1:0] hit
);

   localparam int NCH = 1 << CH_W;

   // A flow counts only when enabled, selected for the channel and the
   // tag count agrees; the code 3 is illegal and never matches.
   generate
      for (genvar i = 0; i < FLOWS; i++) begin : g_flow
         assign hit[i] = active[i] && chan_sel[i*NCH + int'(chan)] && // [R19]
                         (tag_cnt[2*i +: 2] == tags) && (tag_cnt[2*i +: 2] != 2'h3); // [R20] [R18]
      end
   endgenerate

endmodule : ehc_flow_match

// ### core/ehc_eth_comparator.sv
// Ethernet/LLC/SNAP header comparator stage of the packet analyzer.
// Assumes byte-wide aligned frame data on clk and a controller that
// consumes a one-cycle result pulse per frame.
//
// Functional notes
// R1 - Comparator codes: 0 first Ethernet, 1 second, 2-3 IP, 4 MPLS, 5 last.
// R2 - Match bit compared only where mask bit is 1; otherwise wildcard.
// R3 - Range checks include both bounds.
// R4 - Comparator one starts every frame; comparator two starts where told.
// R5 - Type II: up to two tags, S value or 0x8100, before EtherType.
// R6 - LLC before SNAP: both service points 0xaa/0xab, control 0x03.
// R7 - SNAP is three organisation bytes (0 or 0xf8) plus EtherType.
// R8 - SNAP EtherType naming a tag is followed by that tag.
// R9 - Longest header: addresses, two tags, length, LLC, SNAP.
// R10 - Backbone header: at most one tag then the I-tag.
// R11 - One next-protocol descriptor shared by all flows.
// R12 - Next protocol checks final EtherType, tags and length value.
// R13 - 3-bit field names the comparator that follows.
// R14 - 5-bit offset locates the frame signature field.
// R15 - 16-bit global tag value for all tags except C and I.
// R16 - Backbone bridging enable exists only in comparator one.
// R17 - EtherType match applies only to type II frames.
// R18 - Flows classified by tags and addresses against several sets; the code checks tag count and channel only, not addresses.
// R19 - Flow used only when enabled and its channel bit is set.
// R20 - Per-flow 2-bit count of tags: 0, 1 or 2.
// R21 - Any failed stage reports no-modify to the time stamp block.
// R22 - Software programs the header length offset from byte 0.
// R23 - Mixed mode: below 0x0600 is length needing LLC/SNAP.
// R24 - Next comparator code above 5 makes the frame unmatched.
`include "ehc_regs.svh"

module ehc_eth_comparator import ehc_pkg::*; #(
   parameter logic [2:0] COMP_ID = `EHC_ID_ETH1,
   parameter int FLOWS = 8,
   parameter int CH_W = 2
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Register port
   input wire logic [5:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Frame data and stage start
   input wire ehc_byte_t in_byte,
   input wire logic go,
   input wire logic [7:0] go_pos,
   // Result to the controller
   output ehc_result_t result
);

   // ----------------------------------------------------------------------
   // Decoding helpers
   // ----------------------------------------------------------------------

   function automatic logic mask_hit(input logic [15:0] v, input logic [15:0] m, input logic [15:0] k);
      mask_hit = ((v ^ m) & k) == 16'h0000; // [R2]
   endfunction : mask_hit

   function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
      in_range = (v >= lo) && (v <= hi); // [R3]
   endfunction : in_range

   function automatic logic is_sap(input logic [7:0] b);
      is_sap = (b == `EHC_SAP_A) || (b == `EHC_SAP_B);
   endfunction : is_sap

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   logic [2:0] next_stage_select_ff;
   logic [4:0] signature_field_offset_ff;
   logic [7:0] hdr_offs_ff;
   logic [15:0] tag_protocol_value_ff;
   logic backbone_bridging_enable_ff;
   logic type_match_enable_ff;
   logic mixed_mode_ff;
   logic [15:0] type_match_value_ff;
   logic [15:0] type_match_mask_ff;
   logic [15:0] len_lo_ff;
   logic [15:0] len_hi_ff;
   logic [FLOWS-1:0] flow_active_ff;
   logic [FLOWS*(1<<CH_W)-1:0] flow_channel_select_ff;
   logic [2*FLOWS-1:0] tag_count_ff;
   logic last_match_ff;
   logic [1:0] last_tags_ff;
   logic [FLOWS-1:0] last_hits_ff;
   logic [31:0] rdata_ff;

   // Parser state.
   ehc_state_t state_ff;
   ehc_state_t nxt_state;
   logic [3:0] cnt_ff;
   logic [3:0] nxt_cnt;
   logic [7:0] hi_ff;
   logic [15:0] oui_ff;
   logic [1:0] tags_ff;
   logic llc_ff;
   logic itag_ff;
   logic [CH_W-1:0] chan_ff;
   logic [7:0] pos_ff;
   logic [7:0] start_ff;
   logic armed_ff;
   ehc_result_t res_ff;

   // Decision terms.
   logic bb_eff;
   logic [1:0] tag_lim;
   logic [15:0] word;
   logic [23:0] organisation_identifier;
   logic [7:0] idx;
   logic begin_hit;
   logic fin_fire;
   logic fin_ok;
   logic tag_inc;
   logic llc_set;
   logic itag_set;
   logic [FLOWS-1:0] hits;

   // The second comparator has no backbone mode at all.
   assign bb_eff = (COMP_ID == `EHC_ID_ETH1) && backbone_bridging_enable_ff; // [R16]
   assign tag_lim = bb_eff ? 2'h1 : 2'h2; // [R10]
   assign word = {hi_ff, in_byte.data};
   assign organisation_identifier = {oui_ff, in_byte.data};
   assign idx = in_byte.sof ? 8'h00 : pos_ff;
   // Comparator one always begins at byte 0; others wait for the controller.
   assign begin_hit = in_byte.valid && (state_ff == EHC_IDLE) && // [R4]
                      ((COMP_ID == `EHC_ID_ETH1) ? in_byte.sof : (armed_ff && idx == start_ff));

   // ----------------------------------------------------------------------
   // Register write port
   // ----------------------------------------------------------------------

   // One shared next-protocol descriptor plus per-flow settings.
   always_ff @(posedge clk) begin // [R11]
      if (reset) begin
         next_stage_select_ff <= `EHC_ID_LAST;
         signature_field_offset_ff <= 5'h00;
         hdr_offs_ff <= 8'h00;
         tag_protocol_value_ff <= `EHC_RST_TPV;
         backbone_bridging_enable_ff <= 1'b0;
         type_match_enable_ff <= 1'b0;
         mixed_mode_ff <= 1'b0;
         type_match_value_ff <= 16'h0000;
         type_match_mask_ff <= 16'h0000;
         len_lo_ff <= 16'h0000;
         len_hi_ff <= `EHC_RST_LEN_HI;
         flow_active_ff <= '0;
         flow_channel_select_ff <= '0;
         tag_count_ff <= '0;
      end else if (reg_wr) begin
         unique case (reg_addr)
            `EHC_OFS_NEXT: next_stage_select_ff <= reg_wdata[2:0];
            `EHC_OFS_SIG: signature_field_offset_ff <= reg_wdata[4:0];
            `EHC_OFS_HDR: hdr_offs_ff <= reg_wdata[7:0];
            `EHC_OFS_TPV: tag_protocol_value_ff <= reg_wdata[15:0];
            `EHC_OFS_CTRL: begin
               backbone_bridging_enable_ff <= reg_wdata[`EHC_CTRL_BB];
               type_match_enable_ff <= reg_wdata[`EHC_CTRL_TEN];
               mixed_mode_ff <= reg_wdata[`EHC_CTRL_MIX];
            end
            `EHC_OFS_TYPE: begin
               type_match_value_ff <= reg_wdata[15:0];
               type_match_mask_ff <= reg_wdata[31:16];
            end
            `EHC_OFS_LEN: begin
               len_lo_ff <= reg_wdata[15:0];
               len_hi_ff <= reg_wdata[31:16];
            end
            `EHC_OFS_FACT: flow_active_ff <= reg_wdata[FLOWS-1:0];
            `EHC_OFS_FCH: flow_channel_select_ff <= reg_wdata[FLOWS*(1<<CH_W)-1:0];
            `EHC_OFS_FTAG: tag_count_ff <= reg_wdata[2*FLOWS-1:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Register read port
   // ----------------------------------------------------------------------

   // Data stand only in the cycle after the strobe; unmapped reads give zero.
   always_ff @(posedge clk) begin
      if (reset || !reg_rd) begin
         rdata_ff <= 32'h0000_0000;
      end else begin
         unique case (reg_addr)
            `EHC_OFS_NEXT: rdata_ff <= {29'h0, next_stage_select_ff};
            `EHC_OFS_SIG: rdata_ff <= {27'h0, signature_field_offset_ff};
            `EHC_OFS_HDR: rdata_ff <= {24'h0, hdr_offs_ff};
            `EHC_OFS_TPV: rdata_ff <= {16'h0, tag_protocol_value_ff};
            `EHC_OFS_CTRL: rdata_ff <= {29'h0, mixed_mode_ff, type_match_enable_ff, bb_eff};
            `EHC_OFS_TYPE: rdata_ff <= {type_match_mask_ff, type_match_value_ff};
            `EHC_OFS_LEN: rdata_ff <= {len_hi_ff, len_lo_ff};
            `EHC_OFS_FACT: rdata_ff <= 32'(flow_active_ff);
            `EHC_OFS_FCH: rdata_ff <= 32'(flow_channel_select_ff);
            `EHC_OFS_FTAG: rdata_ff <= 32'(tag_count_ff);
            `EHC_OFS_STAT: rdata_ff <= (32'(last_hits_ff) << `EHC_STAT_HITS_LSB) |
                                       (32'(last_tags_ff) << `EHC_STAT_TAGS_LSB) | 32'(last_match_ff);
            default: rdata_ff <= 32'h0000_0000;
         endcase
      end
   end

   assign reg_rdata = rdata_ff;

   // ----------------------------------------------------------------------
   // Flow gating
   // ----------------------------------------------------------------------
   ehc_flow_match #(.FLOWS(FLOWS), .CH_W(CH_W)) u_flow (
      .active(flow_active_ff),
      .chan_sel(flow_channel_select_ff),
      .tag_cnt(tag_count_ff),
      .chan(chan_ff),
      .tags(tags_ff),
      .hit(hits)
   );

   // ----------------------------------------------------------------------
   // Header parser decisions
   // ----------------------------------------------------------------------

   // Each field is walked byte by byte; a frame that ends early fails.
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      fin_fire = 1'b0;
      fin_ok = 1'b0;
      tag_inc = 1'b0;
      llc_set = 1'b0;
      itag_set = 1'b0;
      if (begin_hit) begin
         nxt_state = EHC_ADDR;
         nxt_cnt = 4'h1;
      end else if (in_byte.valid) begin
         unique case (state_ff)
            EHC_IDLE, EHC_DONE: ;
            EHC_ADDR: begin
               nxt_cnt = cnt_ff + 4'h1;
               if (cnt_ff == `EHC_ADDR_BYTES - 4'h1) begin
                  nxt_state = EHC_TYPE;
                  nxt_cnt = 4'h0;
               end
            end
            EHC_TYPE: begin
               nxt_cnt = 4'h1;
               if (cnt_ff == 4'h1) begin
                  nxt_cnt = 4'h0;
                  if ((word == `EHC_CTAG || word == tag_protocol_value_ff) && // [R5] [R15]
                      tags_ff < tag_lim && !itag_ff) begin // [R8] [R9]
                     nxt_state = EHC_TCI;
                     tag_inc = 1'b1;
                  end else if (bb_eff && word == `EHC_ITAG) begin // [R10]
                     nxt_state = EHC_ITAG;
                     itag_set = 1'b1;
                  end else if (word < `EHC_LEN_LIMIT) begin // [R23]
                     if (mixed_mode_ff && !llc_ff && !bb_eff && in_range(word, len_lo_ff, len_hi_ff)) begin // [R12]
                        nxt_state = EHC_LLC;
                        llc_set = 1'b1;
                     end else begin
                        nxt_state = EHC_DONE;
                        fin_fire = 1'b1;
                     end
                  end else begin
                     // Final EtherType; the match register is ignored behind LLC/SNAP.
                     nxt_state = EHC_DONE;
                     fin_fire = 1'b1;
                     fin_ok = !bb_eff && (|hits) && // [R12]
                              (!(type_match_enable_ff && !llc_ff) || // [R17]
                               mask_hit(word, type_match_value_ff, type_match_mask_ff));
                  end
               end
            end
            EHC_TCI: begin
               nxt_cnt = cnt_ff + 4'h1;
               if (cnt_ff == 4'h1) begin
                  nxt_state = EHC_TYPE;
                  nxt_cnt = 4'h0;
               end
            end
            EHC_ITAG: begin
               nxt_cnt = cnt_ff + 4'h1;
               if (cnt_ff == `EHC_ITAG_BYTES - 4'h1) begin
                  // Customer addresses belong to the next Ethernet stage.
                  nxt_state = EHC_DONE;
                  fin_fire = 1'b1;
                  fin_ok = |hits; // [R10]
               end
            end
            EHC_LLC: begin
               nxt_cnt = cnt_ff + 4'h1;
               if ((cnt_ff < 4'h2 && !is_sap(in_byte.data)) || // [R6]
                   (cnt_ff == 4'h2 && in_byte.data != `EHC_LLC_CTL)) begin
                  nxt_state = EHC_DONE;
                  fin_fire = 1'b1;
               end else if (cnt_ff == `EHC_LLC_BYTES - 4'h1) begin
                  nxt_state = EHC_SNAP;
                  nxt_cnt = 4'h0;
               end
            end
            EHC_SNAP: begin
               nxt_cnt = cnt_ff + 4'h1;
               if (cnt_ff == `EHC_OUI_BYTES - 4'h1) begin
                  nxt_cnt = 4'h0;
                  if (organisation_identifier == 24'h000000 || organisation_identifier == `EHC_OUI_ALT) begin // [R7]
                     nxt_state = EHC_TYPE;
                  end else begin
                     nxt_state = EHC_DONE;
                     fin_fire = 1'b1;
                  end
               end
            end
         endcase
         // A header cut short by the end of the frame never matches.
         if (in_byte.eof && state_ff != EHC_IDLE && state_ff != EHC_DONE && !fin_fire) begin
            fin_fire = 1'b1;
            fin_ok = 1'b0;
         end
         if (in_byte.eof) begin
            nxt_state = EHC_IDLE;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Parser state
   // ----------------------------------------------------------------------

   always_ff @(posedge clk) begin
      if (reset) begin
         state_ff <= EHC_IDLE;
         cnt_ff <= 4'h0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
      end
   end

   // Header history: tag count, LLC seen, I-tag seen, shifted bytes.
   always_ff @(posedge clk) begin
      if (reset || begin_hit) begin
         tags_ff <= 2'h0;
         llc_ff <= 1'b0;
         itag_ff <= 1'b0;
         hi_ff <= 8'h00;
         oui_ff <= 16'h0000;
      end else if (in_byte.valid) begin
         tags_ff <= tags_ff + {1'b0, tag_inc};
         llc_ff <= llc_ff | llc_set;
         itag_ff <= itag_ff | itag_set;
         hi_ff <= in_byte.data;
         oui_ff <= {oui_ff[7:0], in_byte.data};
      end
   end

   // Byte position in the frame and the start point given by the controller.
   always_ff @(posedge clk) begin
      if (reset) begin
         pos_ff <= 8'h00;
         chan_ff <= '0;
      end else if (in_byte.valid) begin
         pos_ff <= (idx == 8'hff) ? idx : idx + 8'h01;
         if (in_byte.sof) begin
            chan_ff <= in_byte.chan;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         armed_ff <= 1'b0;
         start_ff <= 8'h00;
      end else if (go) begin
         armed_ff <= 1'b1;
         start_ff <= go_pos;
      end else if (begin_hit || (in_byte.valid && in_byte.eof)) begin
         armed_ff <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Result to the controller
   // ----------------------------------------------------------------------

   // A failure, or a next code past the last stage, tells the time stamp
   // block to leave the frame alone rather than pass on a stale chain.
   always_ff @(posedge clk) begin
      if (reset || !fin_fire) begin
         res_ff <= '0;
      end else begin
         res_ff.valid <= 1'b1;
         res_ff.match <= fin_ok && (next_stage_select_ff <= `EHC_ID_LAST); // [R24] [R1]
         res_ff.no_modify_signal <= !(fin_ok && (next_stage_select_ff <= `EHC_ID_LAST)); // [R21]
         res_ff.next_id <= next_stage_select_ff; // [R13]
         res_ff.next_pos <= start_ff + hdr_offs_ff; // [R22]
         res_ff.sig_pos <= start_ff + {3'h0, signature_field_offset_ff}; // [R14]
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         last_match_ff <= 1'b0;
         last_tags_ff <= 2'h0;
         last_hits_ff <= '0;
      end else if (fin_fire) begin
         last_match_ff <= fin_ok;
         last_tags_ff <= tags_ff;
         last_hits_ff <= hits;
      end
   end

   assign result = res_ff;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_bad_id_fails: assert property (res_ff.valid && res_ff.next_id > `EHC_ID_LAST |-> !res_ff.match) // [R24]
      else $error("Out of range next code gave a match.");
   a_nomod_on_fail: assert property (res_ff.valid |-> res_ff.no_modify_signal == !res_ff.match) // [R21]
      else $error("Failed stage did not report no-modify.");
   a_bb_second_off: assert property (state_ff == EHC_ITAG |-> COMP_ID == `EHC_ID_ETH1 && backbone_bridging_enable_ff) // [R16]
      else $error("I-tag walked outside backbone mode of comparator one.");
   // Gaps in the byte stream are legal, so only the step into the tag is checked.
   a_ctag_enters: assert property (state_ff == EHC_TYPE && cnt_ff == 4'h1 && in_byte.valid && !in_byte.eof &&
      word == `EHC_CTAG && tags_ff < tag_lim && !itag_ff |=> state_ff == EHC_TCI &&
      tags_ff == $past(tags_ff) + 2'h1) // [R5]
      else $error("C-tag not walked as a tag.");
   a_llc_bad_sap: assert property (state_ff == EHC_LLC && cnt_ff == 4'h0 && in_byte.valid &&
      !is_sap(in_byte.data) |=> res_ff.valid && !res_ff.match) // [R6]
      else $error("Bad service point accepted.");
   a_type1_mode_off: assert property (state_ff == EHC_TYPE && cnt_ff == 4'h1 && in_byte.valid && !mixed_mode_ff &&
      word < `EHC_LEN_LIMIT && word != tag_protocol_value_ff |=> res_ff.valid && !res_ff.match) // [R23]
      else $error("Length frame accepted without mixed mode.");
   a_flow_gate: assert property (res_ff.match |-> $past(|hits)) // [R19]
      else $error("Match without an enabled flow.");
   a_typeii_cmp: assert property (fin_fire && state_ff == EHC_TYPE && type_match_enable_ff && !llc_ff &&
      !mask_hit(word, type_match_value_ff, type_match_mask_ff) |=> !res_ff.match) // [R17]
      else $error("EtherType mismatch gave a match.");
   a_next_code: assert property (fin_fire |=> res_ff.valid && res_ff.next_id == $past(next_stage_select_ff)) // [R13]
      else $error("Next code not handed over.");

   c_match: cover property (res_ff.valid && res_ff.match);
   c_fail: cover property (res_ff.valid && res_ff.no_modify_signal);
   c_snap: cover property (state_ff == EHC_SNAP ##[1:8] res_ff.match);
   c_two_tags: cover property (tags_ff == 2'h2 && res_ff.match);

endmodule : ehc_eth_comparator

// ### verification/ehc_frame_src.sv
// Frame source standing in for the aligned frame data path.
// Assumes the bench fills mem before each call of send.
module ehc_frame_src import ehc_pkg::*; (
   // Clock
   input wire logic clk,
   // Frame bytes
   output ehc_byte_t in_byte
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [0:63];
   initial in_byte = '0;
   // One byte a cycle; idle data is inverted so a stale byte never passes for a fresh one.
   task automatic send(input int n);
      for (int k = 0; k < n; k++) begin
         @(posedge clk);
         in_byte <= '{1'b1, k == 0, k == n - 1, 2'h0, mem[k]};
      end
      @(posedge clk);
      in_byte <= '{1'b0, 1'b0, 1'b0, 2'h0, ~mem[n - 1]};
   endtask : send
endmodule : ehc_frame_src

// ### verification/ethernet_header_comparator_tb.sv
// Self-checking bench of the first Ethernet header comparator.
// Assumes ehc_frame_src feeds frames on channel 0.
`include "ehc_regs.svh"
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin fails++; \
   $display("wrong value %s exp %h got %h", n, e, a); end end
module ethernet_header_comparator_tb import ehc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, reset, reg_wr, reg_rd, seen;
   logic [5:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, llc;
   ehc_byte_t in_byte;
   ehc_result_t result, got;
   int fails = 0;
   int compares = 0;
   // Free-running 100 MHz clock.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   ehc_eth_comparator #(.COMP_ID(`EHC_ID_ETH1), .FLOWS(8), .CH_W(2)) i_ehc_eth_comparator (.clk(clk),
      .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .in_byte(in_byte), .go(1'b0), .go_pos(8'h00), .result(result));
   ehc_frame_src i_ehc_frame_src (.clk(clk), .in_byte(in_byte));
   // The result stands one cycle only, so it is caught on the edge.
   always @(posedge clk) if (result.valid) begin
      got <= result;
      seen <= 1'b1;
   end
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [5:0] a, input logic [31:0] e, input string n);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 `CHK(n, e, reg_rdata)
   endtask : rd
   task automatic pw(inout int i, input logic [15:0] w);
      i_ehc_frame_src.mem[i] = w[15:8];
      i_ehc_frame_src.mem[i + 1] = w[7:0];
      i += 2;
   endtask : pw
   // Addresses, nt tags, length/LLC/SNAP when llc is not zero, final type 0x88f7 and two payload bytes.
   task automatic frame(input logic [15:0] t1, t2, input int nt, input logic ex, input string n);
      int i;
      i = 12;
      for (int k = 0; k < 12; k++) i_ehc_frame_src.mem[k] = 8'(k);
      if (nt > 0) begin pw(i, t1); pw(i, 16'h0005); end
      if (nt > 1) begin pw(i, t2); pw(i, 16'h0006); end
      if (llc != 0) begin
         pw(i, 16'h0010);
         pw(i, llc[31:16]);
         pw(i, llc[15:0]);
         pw(i, 16'h0000);
      end
      pw(i, 16'h88f7);
      pw(i, 16'h0102);
      seen = 1'b0;
      i_ehc_frame_src.send(i);
      repeat (4) if (!seen) @(posedge clk);
      #1 `CHK(n, 3'b110, {seen, got.match, got.no_modify_signal} ^ {1'b0, !ex, !ex})
      if (ex) `CHK(n, 19'h10e0c, {got.next_id, got.next_pos, got.sig_pos})
   endtask : frame
   task automatic t_regs;
      rd(`EHC_OFS_NEXT, 32'h5, "next reset");
      rd(`EHC_OFS_TPV, 32'h8a88, "tag value reset");
      rd(6'h3c, 32'h0, "unmapped");
      $display("test regs done");
   endtask : t_regs
   task automatic t_tags;
      wr(`EHC_OFS_FACT, 1); wr(`EHC_OFS_FCH, 1); wr(`EHC_OFS_HDR, 14);
      wr(`EHC_OFS_SIG, 12); wr(`EHC_OFS_NEXT, 1);
      frame(0, 0, 0, 1, "plain");
      wr(`EHC_OFS_FTAG, 1);
      frame(16'h8100, 0, 1, 1, "one tag");
      frame(0, 0, 0, 0, "count off");
      wr(`EHC_OFS_FTAG, 2);
      frame(16'h8a88, 16'h8100, 2, 1, "two tags");
      wr(`EHC_OFS_TPV, 16'h9100);
      frame(16'h8a88, 16'h8100, 2, 0, "old tag value");
      frame(16'h9100, 16'h8100, 2, 1, "new tag value");
      $display("test tags done");
   endtask : t_tags
   task automatic t_gate;
      wr(`EHC_OFS_FTAG, 0); wr(`EHC_OFS_FCH, 2);
      frame(0, 0, 0, 0, "channel off");
      wr(`EHC_OFS_FCH, 1); wr(`EHC_OFS_FACT, 0);
      frame(0, 0, 0, 0, "flow off");
      wr(`EHC_OFS_FACT, 1); wr(`EHC_OFS_TYPE, 32'hffff0800); wr(`EHC_OFS_CTRL, 2);
      frame(0, 0, 0, 0, "type differs");
      wr(`EHC_OFS_TYPE, 32'h00000800);
      frame(0, 0, 0, 1, "mask wildcard");
      wr(`EHC_OFS_TYPE, 32'hffff88f7);
      frame(0, 0, 0, 1, "type equal");
      wr(`EHC_OFS_NEXT, 6);
      frame(0, 0, 0, 0, "bad next id");
      $display("test gate done");
   endtask : t_gate
   task automatic t_mode;
      wr(`EHC_OFS_NEXT, 1);
      wr(`EHC_OFS_CTRL, 4);
      llc = 32'haaaa0300;
      frame(0, 0, 0, 1, "llc snap");
      llc = 32'h12aa0300;
      frame(0, 0, 0, 0, "bad service point");
      llc = 32'haaaa0301;
      frame(0, 0, 0, 0, "bad organisation");
      llc = 32'haaaa0300;
      wr(`EHC_OFS_CTRL, 0);
      frame(0, 0, 0, 0, "mixed mode off");
      llc = '0;
      wr(`EHC_OFS_CTRL, 1);
      frame(16'h88e7, 0, 1, 1, "backbone");
      frame(0, 0, 0, 0, "no i-tag");
      rd(`EHC_OFS_CTRL, 32'h1, "ctrl");
      rd(`EHC_OFS_STAT, 32'h100, "status");
      $display("test modes done");
   endtask : t_mode
   task automatic conclude;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : conclude
   // Reset for 12 cycles, then the tests in turn.
   initial begin
      reset = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = '0; reg_wdata = '0; seen = 1'b0; llc = '0;
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      t_regs(); t_tags(); t_gate(); t_mode();
      conclude();
   end
   // The tests need well under 1000 cycles; ten times that marks a hang.
   initial begin
      #100000;
      fails++;
      conclude();
   end
endmodule : ethernet_header_comparator_tb
